// ===== spc_pkg.sv
package spc_pkg;

    // Register byte addresses, four apart, on the plain register port
    localparam logic [7:0] SPC_ADDR_STANDBY_PIN_CTRL = 8'h00;
    localparam logic [7:0] SPC_ADDR_SYS_CTRL  = 8'h04;
    localparam logic [7:0] SPC_ADDR_CLK_CTRL  = 8'h08;
    localparam logic [7:0] SPC_ADDR_IRQ_EN    = 8'h0C;
    localparam logic [7:0] SPC_ADDR_CLK_DIR   = 8'h10;
    localparam logic [7:0] SPC_ADDR_STATUS    = 8'h14;

    // Field positions
    localparam int SPC_STANDBY_SELECT_BIT_BIT  = 7;
    localparam int SPC_WAIT_MSB  = 6;
    localparam int SPC_WAIT_LSB  = 4;
    localparam int SPC_OPE_BIT   = 3;
    localparam int SPC_NONMASKABLE_EDGE_SELECT_BIT = 2;
    localparam int SPC_RAM_ENABLE_BIT_BIT  = 0;
    localparam int SPC_CLOCK_OUT_STOP_BIT_BIT = 7;
    localparam int SPC_DIR_BIT   = 0;

    // Reset values
    localparam logic [7:0] SPC_STANDBY_PIN_CTRL_RST = 8'h00;
    localparam logic [7:0] SPC_SYS_CTRL_RST  = 8'h01;
    localparam logic [7:0] SPC_CLK_CTRL_RST  = 8'h00;
    localparam logic [7:0] SPC_IRQ_EN_RST    = 8'h00;
    localparam logic [7:0] SPC_CLK_DIR_RST   = 8'h00;
    localparam logic [7:0] SPC_ZERO_BYTE     = 8'h00;

    // Wake wait codes and state counts
    localparam logic [2:0] SPC_WAIT_RESERVED = 3'h6;
    localparam logic [2:0] SPC_WAIT_SHORT    = 3'h7;
    localparam int unsigned SPC_WAIT_8K   = 8192;
    localparam int unsigned SPC_WAIT_16K  = 16384;
    localparam int unsigned SPC_WAIT_32K  = 32768;
    localparam int unsigned SPC_WAIT_64K  = 65536;
    localparam int unsigned SPC_WAIT_128K = 131072;
    localparam int unsigned SPC_WAIT_256K = 262144;
    localparam int unsigned SPC_WAIT_16   = 16;
    localparam int          SPC_CNT_W     = 19;
    localparam int          SPC_IRQ_N     = 3;

    typedef enum logic [2:0] {
        SPC_RUN        = 3'b000,
        SPC_SW_STANDBY_PIN    = 3'b001,
        SPC_OSC_WAIT   = 3'b010,
        SPC_RESET_HOLD = 3'b011,
        SPC_HW_STANDBY_PIN    = 3'b100
    } spc_state_type;

    // External pins, all asynchronous to the system clock
    typedef struct packed {
        logic                 nmi;
        logic [SPC_IRQ_N-1:0] ext_irq_pins_n;
        logic                 reset_pin_n;
        logic                 standby_pin_n;
    } spc_pins_type;

    // Chip-wide power controls
    typedef struct packed {
        logic cpu_stop;
        logic periph_stop;
        logic osc_enable;
        logic clk_supply;
        logic serial_adc_reset;
        logic bus_float;
        logic bus_hold;
        logic all_reset;
        logic io_float;
    } spc_power_type;

endpackage

// ===== spc_standby_power_control.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Sleep with standby select set enters software standby: CPU, peripherals, oscillator stop.
// - Software standby keeps CPU, RAM, ports, peripherals; serial and converter are reset.
// - Output hold bit chooses bus outputs float or hold their level in standby.
// - Only NMI, three IRQ pins, reset pin or standby pin end software standby.
// - Interrupt wake restarts oscillator, waits programmed time, supplies clocks, starts exception.
// - IRQ wakes only if enabled, not CPU-masked, not a transfer-controller source.
// - Reset pin low in standby supplies clocks at once; reset exception on release.
// - Standby pin low enters hardware standby from any mode.
// - Wait field selects 8192 to 262144 states, 110 reserved, 111 gives 16.
// - NMI edge select: 0 falling edge, 1 rising edge.
// - Hardware standby resets and stops everything, floats ports, keeps RAM.
// - Standby pin high with reset low enters reset, oscillates; reset held 8 ms.
// - Clock stop bit holds clock output high after the bus cycle; clear re-enables.
// - Clock pin direction bit 0 disables clock output; pin becomes input.
// - Clock pin floats in hardware standby or direction 0; high in software standby.
module spc_standby_power_control #(
    parameter int unsigned WAIT_CODE0 = spc_pkg::SPC_WAIT_8K,
    parameter int unsigned WAIT_CODE1 = spc_pkg::SPC_WAIT_16K,
    parameter int unsigned WAIT_CODE2 = spc_pkg::SPC_WAIT_32K,
    parameter int unsigned WAIT_CODE3 = spc_pkg::SPC_WAIT_64K,
    parameter int unsigned WAIT_CODE4 = spc_pkg::SPC_WAIT_128K,
    parameter int unsigned WAIT_CODE5 = spc_pkg::SPC_WAIT_256K,
    parameter int unsigned WAIT_CODE7 = spc_pkg::SPC_WAIT_16
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    input  wire spc_pkg::spc_pins_type pins_i,
    input  wire logic                  sleep_exec_i,
    input  wire logic [2:0]            irq_cpu_masked_i,
    input  wire logic [2:0]            irq_xfer_source_i,
    input  wire logic                  bus_cycle_end_i,
    input  wire logic                  clk_phase_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic [7:0]                 reg_rdata_o,
    output spc_pkg::spc_power_type     power_o,
    output logic                       irq_exception_o,
    output logic                       reset_exception_o,
    output logic                       clk_pin_o,
    output logic                       clk_pin_oe_o,
    output spc_pkg::spc_state_type     state_o
);
    import spc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic [1:0]   rst_sync_reg;
    logic         rst_n;
    spc_pins_type pin_meta_reg;
    spc_pins_type pin_sync_reg;
    spc_pins_type pin_prev_reg;
    localparam spc_pins_type PINS_IDLE = '1;

    assign rst_n     = rst_sync_reg[1];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= PINS_IDLE;
            pin_sync_reg <= PINS_IDLE;
            pin_prev_reg <= PINS_IDLE;
        end else begin
            pin_meta_reg <= pins_i;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wait count decode

    function automatic logic [SPC_CNT_W-1:0] wait_count(input logic [2:0] code);
        int unsigned n;
        unique case (code)
            3'h0:    n = WAIT_CODE0;
            3'h1:    n = WAIT_CODE1;
            3'h2:    n = WAIT_CODE2;
            3'h3:    n = WAIT_CODE3;
            3'h4:    n = WAIT_CODE4;
            3'h5:    n = WAIT_CODE5;
            3'h7:    n = WAIT_CODE7;
            default: n = WAIT_CODE0;   // Reserved code falls back to the first setting
        endcase
        return SPC_CNT_W'(n - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    spc_state_type        state_reg, state_next;
    logic [7:0]           standby_pin_ctrl_reg, standby_pin_ctrl_next;
    logic [7:0]           sys_ctrl_reg, sys_ctrl_next;
    logic [7:0]           clk_ctrl_reg, clk_ctrl_next;
    logic [7:0]           irq_en_reg, irq_en_next;
    logic [7:0]           clk_dir_reg, clk_dir_next;
    logic [7:0]           rdata_reg, rdata_next;
    logic [SPC_CNT_W-1:0] wait_cnt_reg, wait_cnt_next;
    logic                 stop_eff_reg, stop_eff_next;
    spc_power_type        power_reg, power_next;
    logic                 irq_exc_reg, irq_exc_next;
    logic                 rst_exc_reg, rst_exc_next;
    logic                 clk_pin_reg, clk_pin_next;
    logic                 clk_oe_reg, clk_oe_next;

    logic                 nmi_edge;
    logic [2:0]           irq_fall;
    logic                 irq_wake;
    logic                 res_low;
    logic                 standby_pin_low;
    logic                 regs_clear;
    logic                 sw_standby_pin;

    always_comb begin
        res_low  = !pin_sync_reg.reset_pin_n;
        standby_pin_low = !pin_sync_reg.standby_pin_n;
        nmi_edge = sys_ctrl_reg[SPC_NONMASKABLE_EDGE_SELECT_BIT]
                 ? (pin_sync_reg.nmi && !pin_prev_reg.nmi)
                 : (!pin_sync_reg.nmi && pin_prev_reg.nmi);
        irq_fall = pin_prev_reg.ext_irq_pins_n & ~pin_sync_reg.ext_irq_pins_n;
        irq_wake = |(irq_fall & irq_en_reg[2:0]
                 & ~irq_cpu_masked_i & ~irq_xfer_source_i);

        state_next    = state_reg;
        wait_cnt_next = wait_cnt_reg;
        irq_exc_next  = 1'b0;
        rst_exc_next  = 1'b0;
        unique case (state_reg)
            SPC_RUN: begin
                if (res_low) begin
                    state_next = SPC_RESET_HOLD;
                end else if (sleep_exec_i && standby_pin_ctrl_reg[SPC_STANDBY_SELECT_BIT_BIT]) begin
                    state_next = SPC_SW_STANDBY_PIN;
                end
            end
            SPC_SW_STANDBY_PIN: begin
                if (res_low) begin
                    state_next = SPC_RESET_HOLD;
                end else if (nmi_edge || irq_wake) begin
                    state_next    = SPC_OSC_WAIT;
                    wait_cnt_next = wait_count(standby_pin_ctrl_reg[SPC_WAIT_MSB:SPC_WAIT_LSB]);
                end
            end
            SPC_OSC_WAIT: begin
                if (res_low) begin
                    state_next = SPC_RESET_HOLD;
                end else if (wait_cnt_reg == '0) begin
                    state_next   = SPC_RUN;
                    irq_exc_next = 1'b1;
                end else begin
                    wait_cnt_next = wait_cnt_reg - 1'b1;
                end
            end
            SPC_RESET_HOLD: begin
                if (!res_low) begin
                    state_next   = SPC_RUN;
                    rst_exc_next = 1'b1;
                end
            end
            SPC_HW_STANDBY_PIN: begin
                if (!standby_pin_low && res_low) begin
                    state_next = SPC_RESET_HOLD;
                end
            end
            default: state_next = SPC_HW_STANDBY_PIN;
        endcase
        if (standby_pin_low) begin
            state_next   = SPC_HW_STANDBY_PIN;
            irq_exc_next = 1'b0;
            rst_exc_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port

    always_comb begin
        regs_clear     = res_low || standby_pin_low;
        standby_pin_ctrl_next = standby_pin_ctrl_reg;
        sys_ctrl_next  = sys_ctrl_reg;
        clk_ctrl_next  = clk_ctrl_reg;
        irq_en_next    = irq_en_reg;
        clk_dir_next   = clk_dir_reg;
        rdata_next     = SPC_ZERO_BYTE;
        if (regs_clear) begin
            standby_pin_ctrl_next = SPC_STANDBY_PIN_CTRL_RST;
            sys_ctrl_next  = SPC_SYS_CTRL_RST;
            clk_ctrl_next  = SPC_CLK_CTRL_RST;
            irq_en_next    = SPC_IRQ_EN_RST;
            clk_dir_next   = SPC_CLK_DIR_RST;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                SPC_ADDR_STANDBY_PIN_CTRL: standby_pin_ctrl_next = {reg_wdata_i[7:3], 3'b000};
                SPC_ADDR_SYS_CTRL:  sys_ctrl_next  = {5'b00000, reg_wdata_i[2], 1'b0,
                                                      reg_wdata_i[0]};
                SPC_ADDR_CLK_CTRL:  clk_ctrl_next  = {reg_wdata_i[7], 7'b0000000};
                SPC_ADDR_IRQ_EN:    irq_en_next    = {5'b00000, reg_wdata_i[2:0]};
                SPC_ADDR_CLK_DIR:   clk_dir_next   = {7'b0000000, reg_wdata_i[0]};
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                SPC_ADDR_STANDBY_PIN_CTRL: rdata_next = standby_pin_ctrl_reg;
                SPC_ADDR_SYS_CTRL:  rdata_next = sys_ctrl_reg;
                SPC_ADDR_CLK_CTRL:  rdata_next = clk_ctrl_reg;
                SPC_ADDR_IRQ_EN:    rdata_next = irq_en_reg;
                SPC_ADDR_CLK_DIR:   rdata_next = clk_dir_reg;
                SPC_ADDR_STATUS:    rdata_next = {5'b00000, state_reg};
                default:            rdata_next = SPC_ZERO_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power controls and clock pin

    always_comb begin
        sw_standby_pin       = (state_next == SPC_SW_STANDBY_PIN) || (state_next == SPC_OSC_WAIT);
        stop_eff_next = regs_clear ? 1'b0
                      : (bus_cycle_end_i ? clk_ctrl_reg[SPC_CLOCK_OUT_STOP_BIT_BIT] : stop_eff_reg);

        power_next.cpu_stop         = (state_next != SPC_RUN);
        power_next.periph_stop      = sw_standby_pin || (state_next == SPC_HW_STANDBY_PIN);
        power_next.osc_enable       = (state_next != SPC_SW_STANDBY_PIN)
                                   && (state_next != SPC_HW_STANDBY_PIN);
        power_next.clk_supply       = (state_next == SPC_RUN)
                                   || (state_next == SPC_RESET_HOLD);
        power_next.serial_adc_reset = sw_standby_pin;
        power_next.bus_float        = (sw_standby_pin && !standby_pin_ctrl_reg[SPC_OPE_BIT])
                                   || (state_next == SPC_HW_STANDBY_PIN);
        power_next.bus_hold         = sw_standby_pin && standby_pin_ctrl_reg[SPC_OPE_BIT];
        power_next.all_reset        = (state_next == SPC_HW_STANDBY_PIN)
                                   || (state_next == SPC_RESET_HOLD);
        power_next.io_float         = (state_next == SPC_HW_STANDBY_PIN);

        clk_oe_next  = clk_dir_reg[SPC_DIR_BIT] && (state_next != SPC_HW_STANDBY_PIN);
        clk_pin_next = sw_standby_pin || stop_eff_next || clk_phase_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= SPC_RUN;
            standby_pin_ctrl_reg <= SPC_STANDBY_PIN_CTRL_RST;
            sys_ctrl_reg  <= SPC_SYS_CTRL_RST;
            clk_ctrl_reg  <= SPC_CLK_CTRL_RST;
            irq_en_reg    <= SPC_IRQ_EN_RST;
            clk_dir_reg   <= SPC_CLK_DIR_RST;
            rdata_reg     <= SPC_ZERO_BYTE;
            wait_cnt_reg  <= '0;
            stop_eff_reg  <= 1'b0;
            power_reg     <= '0;
            irq_exc_reg   <= 1'b0;
            rst_exc_reg   <= 1'b0;
            clk_pin_reg   <= 1'b1;
            clk_oe_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            standby_pin_ctrl_reg <= standby_pin_ctrl_next;
            sys_ctrl_reg  <= sys_ctrl_next;
            clk_ctrl_reg  <= clk_ctrl_next;
            irq_en_reg    <= irq_en_next;
            clk_dir_reg   <= clk_dir_next;
            rdata_reg     <= rdata_next;
            wait_cnt_reg  <= wait_cnt_next;
            stop_eff_reg  <= stop_eff_next;
            power_reg     <= power_next;
            irq_exc_reg   <= irq_exc_next;
            rst_exc_reg   <= rst_exc_next;
            clk_pin_reg   <= clk_pin_next;
            clk_oe_reg    <= clk_oe_next;
        end
    end

    assign reg_rdata_o       = rdata_reg;
    assign power_o           = power_reg;
    assign irq_exception_o   = irq_exc_reg;
    assign reset_exception_o = rst_exc_reg;
    assign clk_pin_o         = clk_pin_reg;
    assign clk_pin_oe_o      = clk_oe_reg;
    assign state_o           = state_reg;

endmodule

`default_nettype wire

// ===== spc_standby_power_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module spc_standby_power_control_checker (
    input wire logic                   clk_sys_i,
    input wire logic                   rst_n_i,
    input wire logic                   sleep_exec_i,
    input wire spc_pkg::spc_power_type power_o,
    input wire logic                   irq_exception_o,
    input wire logic                   reset_exception_o,
    input wire logic                   clk_pin_oe_o,
    input wire spc_pkg::spc_state_type state_o
);
    import spc_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sleep_entry_a: assert property ($rose(state_o == SPC_SW_STANDBY_PIN) |-> $past(sleep_exec_i))
        else $error("standby entered without sleep");
    standby_pin_stop_a: assert property (state_o == SPC_SW_STANDBY_PIN |->
        power_o.cpu_stop && power_o.periph_stop && !power_o.osc_enable)
        else $error("standby did not stop clocks");
    standby_pin_retain_a: assert property (state_o == SPC_SW_STANDBY_PIN |->
        power_o.serial_adc_reset && !power_o.all_reset)
        else $error("standby retention wrong");
    bus_hold_a: assert property (state_o == SPC_SW_STANDBY_PIN |->
        power_o.bus_float ^ power_o.bus_hold)
        else $error("bus outputs neither held nor floated");
    standby_pin_exit_a: assert property (state_o == SPC_SW_STANDBY_PIN ##1 state_o != SPC_SW_STANDBY_PIN |->
        state_o inside {SPC_OSC_WAIT, SPC_RESET_HOLD, SPC_HW_STANDBY_PIN})
        else $error("standby left by a wrong cause");
    osc_wait_a: assert property (state_o == SPC_OSC_WAIT |->
        power_o.osc_enable && !power_o.clk_supply)
        else $error("clocks supplied during wait");
    irq_done_a: assert property ($rose(irq_exception_o) |->
        $past(state_o) == SPC_OSC_WAIT && state_o == SPC_RUN ##1 !irq_exception_o)
        else $error("interrupt exception out of place");
    reset_clk_a: assert property (state_o == SPC_RESET_HOLD |->
        power_o.clk_supply && power_o.all_reset)
        else $error("reset hold without clocks");
    reset_pulse_a: assert property (reset_exception_o |->
        $past(state_o) == SPC_RESET_HOLD ##1 !reset_exception_o)
        else $error("reset exception out of place");
    hw_float_a: assert property (state_o == SPC_HW_STANDBY_PIN |->
        power_o.all_reset && power_o.io_float && !clk_pin_oe_o)
        else $error("hardware standby not floating");
    cover property (irq_exception_o);
    cover property (reset_exception_o);
    cover property (state_o == SPC_HW_STANDBY_PIN);
endmodule
bind spc_standby_power_control spc_standby_power_control_checker u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sleep_exec_i(sleep_exec_i),
    .power_o(power_o), .irq_exception_o(irq_exception_o),
    .reset_exception_o(reset_exception_o), .clk_pin_oe_o(clk_pin_oe_o), .state_o(state_o));
`default_nettype wire

// ===== spc_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module spc_board_model #(
    parameter int HOLD = 8
) (
    input  wire logic           clk_i,
    input  wire logic           rst_req_i,
    input  wire logic           standby_pin_req_i,
    input  wire logic           nmi_i,
    input  wire logic [2:0]     irq_n_i,
    output var spc_pkg::spc_pins_type pins_o
);
    import spc_pkg::*;
    int held = 0;
    initial pins_o = '1;
    always @(posedge clk_i) begin
        // Hold time counts only once the standby pin is high again
        held <= (pins_o.reset_pin_n || !pins_o.standby_pin_n) ? 0 : held + 1;
        // Mode pins are not modelled: they stay fixed through hardware standby
        pins_o.nmi <= nmi_i;
        pins_o.ext_irq_pins_n <= irq_n_i;
        // Reset only released after a long low phase with standby high
        if (rst_req_i)
            pins_o.reset_pin_n <= 1'b0;
        else if (held >= HOLD && pins_o.standby_pin_n)
            pins_o.reset_pin_n <= 1'b1;
        if (!standby_pin_req_i)
            pins_o.standby_pin_n <= 1'b1;
        else if (!pins_o.reset_pin_n)
            pins_o.standby_pin_n <= 1'b0;
    end
endmodule
`default_nettype wire

// ===== test_standby_power_control.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module test_standby_power_control;
    import spc_pkg::*;
    // External clock assumed, no flash variant: shortened waits, every code legal
    localparam int WT[8] = '{20, 30, 40, 50, 60, 70, 20, 4};
    logic clk_sys = 0, rst_n = 0, sleep = 0, bus_end = 0, phase = 0, reg_wr = 0, reg_rd = 0;
    logic rst_req = 0, standby_pin_req = 0, nmi = 1;
    logic [2:0] masked = 0, xfer = 0, irq_n = 3'b111;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic irq_exc, rst_exc, cpin, cpin_oe;
    spc_power_type pwr;
    spc_state_type st;
    spc_pins_type pins;
    int fail_count = 0, checked = 0, cycles = 0;
    always #25 clk_sys = ~clk_sys;
    spc_board_model #(.HOLD(10)) u_board (.clk_i(clk_sys), .rst_req_i(rst_req),
        .standby_pin_req_i(standby_pin_req), .nmi_i(nmi), .irq_n_i(irq_n), .pins_o(pins));
    spc_standby_power_control #(.WAIT_CODE0(WT[0]), .WAIT_CODE1(WT[1]), .WAIT_CODE2(WT[2]),
        .WAIT_CODE3(WT[3]), .WAIT_CODE4(WT[4]), .WAIT_CODE5(WT[5]), .WAIT_CODE7(WT[7])) DUT (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .pins_i(pins), .sleep_exec_i(sleep),
        .irq_cpu_masked_i(masked), .irq_xfer_source_i(xfer), .bus_cycle_end_i(bus_end),
        .clk_phase_i(phase), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .power_o(pwr), .irq_exception_o(irq_exc),
        .reset_exception_o(rst_exc), .clk_pin_o(cpin), .clk_pin_oe_o(cpin_oe), .state_o(st));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        #1 `CHK("reg_rdata_o", e, rdata)
        cyc(1);
    endtask
    task automatic wait_st(input spc_state_type s);
        int n;
        n = 0;
        while (st !== s && n < 40) begin
            cyc(1);
            #1 n++;
        end
        `CHK("state_o", s, st)
    endtask
    task automatic sleep_in(input logic [7:0] v);
        wr(SPC_ADDR_STANDBY_PIN_CTRL, v);
        sleep <= 1'b1; // No external write is pending when sleep is issued
        cyc(1);
        sleep <= 1'b0;
        cyc(2);
        #1 `CHK("state_o", SPC_SW_STANDBY_PIN, st)
    endtask
    task automatic wake(input int e);
        int n;
        n = 0;
        wait_st(SPC_OSC_WAIT);
        while (st === SPC_OSC_WAIT && n < 400) begin
            cyc(1);
            #1 n++;
        end
        `CHK("wake wait", e, n)
        `CHK("irq_exception_o", 1'b1, irq_exc)
        `CHK("clk_supply", 1'b1, pwr.clk_supply)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(SPC_ADDR_STANDBY_PIN_CTRL, SPC_STANDBY_PIN_CTRL_RST);
        rd(SPC_ADDR_SYS_CTRL, SPC_SYS_CTRL_RST);
        rd(SPC_ADDR_CLK_CTRL, SPC_CLK_CTRL_RST);
        rd(SPC_ADDR_IRQ_EN, SPC_IRQ_EN_RST);
        rd(SPC_ADDR_CLK_DIR, SPC_CLK_DIR_RST);
        wr(SPC_ADDR_STATUS, 8'hFF);
        rd(SPC_ADDR_STATUS, SPC_ZERO_BYTE);
        rd(8'h18, SPC_ZERO_BYTE);
        wr(SPC_ADDR_STANDBY_PIN_CTRL, 8'hE8);
        rd(SPC_ADDR_STANDBY_PIN_CTRL, 8'hE8);
    endtask
    task automatic t_codes();
        wr(SPC_ADDR_CLK_DIR, 8'h01);
        wr(SPC_ADDR_SYS_CTRL, 8'h04);
        for (int c = 0; c < 8; c++) begin
            sleep_in({1'b1, c[2:0], 1'b1, 3'b000});
            `CHK("bus_hold", 1'b1, pwr.bus_hold)
            `CHK("clk_pin_o", 1'b1, cpin)
            `CHK("clk_pin_oe_o", 1'b1, cpin_oe)
            nmi <= 1'b0;
            cyc(8);
            #1 `CHK("state_o", SPC_SW_STANDBY_PIN, st)
            nmi <= 1'b1;
            wake(WT[c]);
        end
        wr(SPC_ADDR_SYS_CTRL, 8'h00);
        sleep_in(8'hF8);
        nmi <= 1'b0;
        wake(WT[7]);
        nmi <= 1'b1;
    endtask
    task automatic t_irq();
        wr(SPC_ADDR_IRQ_EN, 8'h01);
        sleep_in(8'h80);
        `CHK("bus_float", 1'b1, pwr.bus_float)
        for (int k = 0; k < 4; k++) begin
            masked <= (k == 0) ? 3'b001 : 3'b000;
            xfer <= (k == 1) ? 3'b001 : 3'b000;
            irq_n <= (k == 2) ? 3'b101 : 3'b110;
            if (k == 3) break;
            cyc(8);
            irq_n <= 3'b111;
            cyc(4);
            #1 `CHK("state_o", SPC_SW_STANDBY_PIN, st)
        end
        wake(WT[0]);
        irq_n <= 3'b111;
    endtask
    task automatic t_reset();
        sleep_in(8'hF8);
        rst_req <= 1'b1;
        wait_st(SPC_RESET_HOLD);
        `CHK("clk_supply", 1'b1, pwr.clk_supply)
        rst_req <= 1'b0;
        wait_st(SPC_RUN);
        `CHK("reset_exception_o", 1'b1, rst_exc)
        rd(SPC_ADDR_STANDBY_PIN_CTRL, SPC_STANDBY_PIN_CTRL_RST);
    endtask
    task automatic t_hw();
        wr(SPC_ADDR_SYS_CTRL, 8'h00);
        rd(SPC_ADDR_SYS_CTRL, 8'h00);
        sleep_in(8'hF8);
        rst_req <= 1'b1;
        standby_pin_req <= 1'b1;
        wait_st(SPC_HW_STANDBY_PIN);
        `CHK("io_float", 1'b1, pwr.io_float)
        `CHK("all_reset", 1'b1, pwr.all_reset)
        `CHK("clk_pin_oe_o", 1'b0, cpin_oe)
        standby_pin_req <= 1'b0;
        wait_st(SPC_RESET_HOLD);
        rst_req <= 1'b0;
        wait_st(SPC_RUN);
        rd(SPC_ADDR_SYS_CTRL, SPC_SYS_CTRL_RST);
    endtask
    task automatic t_clk();
        wr(SPC_ADDR_CLK_DIR, 8'h00);
        cyc(1);
        #1 `CHK("clk_pin_oe_o", 1'b0, cpin_oe)
        wr(SPC_ADDR_CLK_DIR, 8'h01);
        for (int p = 0; p < 2; p++) begin
            phase <= p[0];
            cyc(3);
            #1 `CHK("clk_pin_o", p[0], cpin)
        end
        phase <= 1'b0;
        for (int s = 1; s >= 0; s--) begin
            wr(SPC_ADDR_CLK_CTRL, {s[0], 7'h00});
            #1 `CHK("clk_pin_o", !s[0], cpin)
            bus_end <= 1'b1;
            cyc(1);
            bus_end <= 1'b0;
            cyc(2);
            #1 `CHK("clk_pin_o", s[0], cpin)
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(4);
        t_regs();
        t_codes();
        t_irq();
        t_reset();
        t_hw();
        t_clk();
        close_out();
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
endmodule
`default_nettype wire
